// File: src/dtu_pkg.sv
// Shared constants and types of the debug trigger and capture unit
package dtu_pkg;

    // ------------------------------------------------------------
    // Widths and depth
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int ENT_W = 16;
    localparam int DEPTH = 8;
    localparam int CNT_W = 4;
    localparam int IRQ_W = 3;
    localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
    localparam logic [CNT_W-1:0] CNT_LAST = 4'h7;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_CMPA = 5'h04;
    localparam logic [4:0] OFF_CMPB = 5'h08;
    localparam logic [4:0] OFF_STAT = 5'h0c;
    localparam logic [4:0] OFF_FIFO = 5'h10;
    localparam logic [4:0] OFF_ISTAT = 5'h14;
    localparam logic [4:0] OFF_IMASK = 5'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CB_ARM = 0;
    localparam int CB_MODE = 1;
    localparam int CB_DQEA = 4;
    localparam int CB_DSA = 5;
    localparam int CB_DQEB = 6;
    localparam int CB_DSB = 7;
    localparam int CB_OPTRK = 8;
    localparam int SB_ARMED = 4;
    localparam int SB_ALIGNED = 5;
    localparam int SB_TRACING = 6;
    localparam int IB_MATCH = 0;
    localparam int IB_FULL = 1;
    localparam int IB_BRK = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CMP_RST = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

    // ------------------------------------------------------------
    // Trigger modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_A_ONLY = 3'h0,
        MODE_A_OR_B = 3'h1,
        MODE_A_DATA = 3'h2,
        MODE_INSIDE = 3'h3,
        MODE_OUTSIDE = 3'h4,
        MODE_CAP_DATA = 3'h5,
        MODE_TRACE_BEGIN = 3'h6,
        MODE_TRACE_END = 3'h7
    } dtu_mode_e;

endpackage

// File: src/dtu_fifo_if.sv
// Connection between the trigger logic and the capture store
`timescale 1ns/1ps
interface dtu_fifo_if;
    logic clear;
    logic push;
    logic [15:0] push_data;
    logic align_en;
    logic pop;
    logic [3:0] count;
    logic [3:0] gap;
    logic [15:0] head;

    modport ctrl (
        output clear, push, push_data, align_en, pop,
        input count, gap, head
    );
    modport store (
        input clear, push, push_data, align_en, pop,
        output count, gap, head
    );
endinterface

// File: src/dtu_cmp.sv
// One 16-bit comparator with equality and magnitude outputs
`timescale 1ns/1ps
module dtu_cmp (
    // Operands
    input wire logic [15:0] ref_val,
    input wire logic [15:0] probe,
    // Results
    output logic eq,
    output logic probe_ge,
    output logic probe_le
);

    assign eq = (probe == ref_val);
    assign probe_ge = (probe >= ref_val);
    assign probe_le = (probe <= ref_val);

endmodule // dtu_cmp

// File: src/dtu_fifo.sv
// Eight-entry capture store: shift-in at the bottom, read from the top
`timescale 1ns/1ps
module dtu_fifo (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control side
    dtu_fifo_if.store fi
);

    logic [dtu_pkg::ENT_W-1:0] mem_r [dtu_pkg::DEPTH];
    logic [dtu_pkg::CNT_W-1:0] count_r;
    logic [dtu_pkg::CNT_W-1:0] gap_r;
    logic shift_up;

    // Alignment moves entries one slot per cycle toward the read end
    assign shift_up = fi.pop || (fi.align_en && gap_r != '0 && !fi.push);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    always_ff @(posedge hclk) begin
        if (fi.push) begin
            mem_r[0] <= fi.push_data;
            for (int i = 1; i < dtu_pkg::DEPTH; i++) begin
                mem_r[i] <= mem_r[i-1];
            end
        end else if (shift_up) begin
            mem_r[0] <= '0;
            for (int i = 1; i < dtu_pkg::DEPTH; i++) begin
                mem_r[i] <= mem_r[i-1];
            end
        end
    end

    // ------------------------------------------------------------
    // Count and distance of the oldest entry from the read end
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= '0;
            gap_r <= dtu_pkg::CNT_FULL;
        end else if (fi.clear) begin
            count_r <= '0;
            gap_r <= dtu_pkg::CNT_FULL;
        end else if (fi.push && count_r != dtu_pkg::CNT_FULL) begin
            count_r <= count_r + 4'h1;
            gap_r <= gap_r - 4'h1;
        end else if (fi.pop && count_r != '0) begin
            count_r <= count_r - 4'h1;
        end else if (shift_up && gap_r != '0) begin
            gap_r <= gap_r - 4'h1;
        end
    end

    assign fi.count = count_r;
    assign fi.gap = gap_r;
    assign fi.head = mem_r[dtu_pkg::DEPTH-1];

endmodule // dtu_fifo

// File: src/dtu_unit.sv
// Debug trigger unit: comparators, trigger modes, capture control, AHB-Lite registers
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module dtu_unit (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Monitored processor bus
    input wire logic cpu_valid,
    input wire logic cpu_rw,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic [7:0] cpu_rdata,
    input wire logic cpu_exec,
    input wire logic [15:0] cpu_exec_addr,
    input wire logic cpu_cof,
    input wire logic background_debug_port_busy,
    // Requests out
    output logic brk_req,
    output logic irq
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic armed_r;
    dtu_pkg::dtu_mode_e mode_r;
    logic dir_qualify_enable_a;
    logic dir_select_a;
    logic dir_qualify_enable_b;
    logic dir_select_b;
    logic optrk_r;
    logic [15:0] cmpa_r;
    logic [15:0] cmpb_r;
    logic [2:0] istat_r;
    logic [2:0] imask_r;
    logic tracing_r;
    logic brk_r;
    logic irq_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic wr_pend_r;
    logic [4:0] waddr_r;
    logic fifo_wait_r;

    dtu_fifo_if fif ();

    dtu_fifo u_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .fi(fif.store)
    );

    // ------------------------------------------------------------
    // Monitored cycle selection
    // ------------------------------------------------------------
    logic mon_valid;
    logic mon_read;
    logic [15:0] mon_addr;
    logic cycle_ok;
    logic [7:0] b_data;
    logic b_on_data;
    logic [15:0] b_probe;

    assign mon_valid = optrk_r ? cpu_exec : cpu_valid;
    assign mon_addr = optrk_r ? cpu_exec_addr : cpu_addr;
    assign mon_read = optrk_r ? 1'b1 : cpu_rw;
    assign cycle_ok = mon_valid && !background_debug_port_busy;
    assign b_data = (dir_qualify_enable_a && !dir_select_a) ? cpu_wdata : cpu_rdata;
    assign b_on_data = (mode_r == dtu_pkg::MODE_A_DATA);
    assign b_probe = b_on_data ? {8'h00, b_data} : mon_addr;

    // ------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------
    logic a_eq;
    logic a_ge;
    logic b_eq;
    logic b_le;

    dtu_cmp u_cmp_a (
        .ref_val(cmpa_r),
        .probe(mon_addr),
        .eq(a_eq),
        .probe_ge(a_ge),
        .probe_le()
    );

    dtu_cmp u_cmp_b (
        .ref_val(b_on_data ? {8'h00, cmpb_r[7:0]} : cmpb_r),
        .probe(b_probe),
        .eq(b_eq),
        .probe_ge(),
        .probe_le(b_le)
    );

    // ------------------------------------------------------------
    // Match qualification
    // ------------------------------------------------------------
    logic dir_ok_a;
    logic dir_ok_b;
    logic hit_a;
    logic hit_b;
    logic in_rng;
    logic match;
    logic qual;
    logic brk_mode;

    assign dir_ok_a = !dir_qualify_enable_a || (mon_read == dir_select_a);
    assign dir_ok_b = !dir_qualify_enable_b || (mon_read == dir_select_b);
    assign hit_a = cycle_ok && dir_ok_a && a_eq;
    assign hit_b = cycle_ok && dir_ok_b && b_eq;
    assign in_rng = a_ge && b_le;

    always_comb begin
        unique case (mode_r)
            dtu_pkg::MODE_A_ONLY: match = hit_a;
            dtu_pkg::MODE_A_OR_B: match = hit_a || hit_b;
            dtu_pkg::MODE_A_DATA: match = hit_a && hit_b;
            dtu_pkg::MODE_INSIDE: match = cycle_ok && dir_ok_a && in_rng;
            dtu_pkg::MODE_OUTSIDE: match = cycle_ok && dir_ok_a && !in_rng;
            dtu_pkg::MODE_CAP_DATA: match = hit_a;
            dtu_pkg::MODE_TRACE_BEGIN: match = hit_a;
            dtu_pkg::MODE_TRACE_END: match = hit_a;
        endcase
    end

    assign qual = match && armed_r;
    assign brk_mode = (mode_r <= dtu_pkg::MODE_OUTSIDE);

    // ------------------------------------------------------------
    // Capture path
    // ------------------------------------------------------------
    logic not_full;
    logic push_data_ev;
    logic push_trace_ev;
    logic push_now;
    logic fills;

    assign not_full = (fif.count != dtu_pkg::CNT_FULL);
    assign push_data_ev = qual && (mode_r == dtu_pkg::MODE_CAP_DATA);
    assign push_trace_ev = armed_r && tracing_r && cpu_cof && !background_debug_port_busy;
    assign push_now = (push_data_ev || push_trace_ev) && not_full && !fif.clear;
    assign fills = push_now && (fif.count == dtu_pkg::CNT_LAST);

    assign fif.push = push_now;
    assign fif.push_data = push_data_ev ? {8'h00, b_data} : cpu_addr;
    assign fif.align_en = !armed_r;

    // ------------------------------------------------------------
    // AHB-Lite decode
    // ------------------------------------------------------------
    logic ap;
    logic ap_rd_fifo;
    logic fifo_empty_view;
    logic fifo_ready;
    logic wr_ctrl;
    logic wr_arm_rise;

    assign ap = hsel && htrans[1] && hready;
    assign ap_rd_fifo = ap && !hwrite && (haddr[4:0] == dtu_pkg::OFF_FIFO);
    assign fifo_empty_view = armed_r || (fif.count == '0);
    assign fifo_ready = (fif.gap == '0);
    assign fif.pop = (ap_rd_fifo && !fifo_empty_view && fifo_ready)
        || (fifo_wait_r && fifo_ready);
    assign wr_ctrl = wr_pend_r && (waddr_r == dtu_pkg::OFF_CTRL);
    assign wr_arm_rise = wr_ctrl && hwdata[dtu_pkg::CB_ARM] && !armed_r;
    assign fif.clear = wr_arm_rise;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            waddr_r <= '0;
        end else if (hready) begin
            wr_pend_r <= ap && hwrite;
            waddr_r <= haddr[4:0];
        end
    end

    // Read data and wait states; only a store read during alignment waits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= '0;
            hreadyout_r <= 1'b1;
            fifo_wait_r <= 1'b0;
        end else if (fifo_wait_r) begin
            if (fifo_ready) begin
                hrdata_r <= {16'h0000, fif.head};
                hreadyout_r <= 1'b1;
                fifo_wait_r <= 1'b0;
            end
        end else if (ap && !hwrite) begin
            hrdata_r <= '0;
            unique case (haddr[4:0])
                dtu_pkg::OFF_CTRL: hrdata_r[8:0] <= {optrk_r, dir_select_b,
                    dir_qualify_enable_b, dir_select_a, dir_qualify_enable_a, mode_r, armed_r};
                dtu_pkg::OFF_CMPA: hrdata_r[15:0] <= cmpa_r;
                dtu_pkg::OFF_CMPB: hrdata_r[15:0] <= cmpb_r;
                dtu_pkg::OFF_STAT: hrdata_r[6:0] <= {tracing_r, fifo_ready, armed_r,
                    fif.count};
                dtu_pkg::OFF_FIFO: begin
                    if (!fifo_empty_view && fifo_ready) begin
                        hrdata_r[15:0] <= fif.head;
                    end else if (!fifo_empty_view) begin
                        hreadyout_r <= 1'b0;
                        fifo_wait_r <= 1'b1;
                    end
                end
                dtu_pkg::OFF_ISTAT: hrdata_r[2:0] <= istat_r;
                dtu_pkg::OFF_IMASK: hrdata_r[2:0] <= imask_r;
                default: hrdata_r <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control register and arming
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r <= dtu_pkg::MODE_A_ONLY;
            dir_qualify_enable_a <= 1'b0;
            dir_select_a <= 1'b0;
            dir_qualify_enable_b <= 1'b0;
            dir_select_b <= 1'b0;
            optrk_r <= 1'b0;
        end else if (wr_ctrl) begin
            mode_r <= dtu_pkg::dtu_mode_e'(hwdata[dtu_pkg::CB_MODE +: 3]);
            dir_qualify_enable_a <= hwdata[dtu_pkg::CB_DQEA];
            dir_select_a <= hwdata[dtu_pkg::CB_DSA];
            dir_qualify_enable_b <= hwdata[dtu_pkg::CB_DQEB];
            dir_select_b <= hwdata[dtu_pkg::CB_DSB];
            optrk_r <= hwdata[dtu_pkg::CB_OPTRK];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed_r <= 1'b0;
        end else if (wr_ctrl) begin
            armed_r <= hwdata[dtu_pkg::CB_ARM];
        end else if (fills) begin
            armed_r <= 1'b0;
        end
    end

    // Trace window: begin-type opens on match, end-type runs from arming to match
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tracing_r <= 1'b0;
        end else if (wr_arm_rise) begin
            tracing_r <= (hwdata[dtu_pkg::CB_MODE +: 3] == dtu_pkg::MODE_TRACE_END);
        end else if (qual && mode_r == dtu_pkg::MODE_TRACE_BEGIN) begin
            tracing_r <= 1'b1;
        end else if (qual && mode_r == dtu_pkg::MODE_TRACE_END) begin
            tracing_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Comparator values
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmpa_r <= dtu_pkg::CMP_RST;
            cmpb_r <= dtu_pkg::CMP_RST;
        end else if (wr_pend_r) begin
            if (waddr_r == dtu_pkg::OFF_CMPA) begin
                cmpa_r <= hwdata[15:0];
            end
            if (waddr_r == dtu_pkg::OFF_CMPB) begin
                cmpb_r <= hwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Breakpoint and interrupts
    // ------------------------------------------------------------
    logic [2:0] ev;
    logic [2:0] w1c;

    assign ev = {qual && brk_mode, fills, qual};
    assign w1c = (wr_pend_r && waddr_r == dtu_pkg::OFF_ISTAT) ? hwdata[2:0] : 3'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            brk_r <= 1'b0;
        end else begin
            brk_r <= qual && brk_mode;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            istat_r <= dtu_pkg::IRQ_RST;
            imask_r <= dtu_pkg::IRQ_RST;
        end else begin
            istat_r <= (istat_r & ~w1c) | ev;
            if (wr_pend_r && waddr_r == dtu_pkg::OFF_IMASK) begin
                imask_r <= hwdata[2:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(istat_r & imask_r);
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = 1'b0;
    assign brk_req = brk_r;
    assign irq = irq_r;

endmodule // dtu_unit

// File: bench/dtu_unit_assertions.sv
// Port assertions of the debug trigger unit
`timescale 1ns/1ps
module dtu_unit_assertions (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // Processor side
    input wire logic cpu_valid,
    input wire logic cpu_exec,
    input wire logic background_debug_port_busy,
    input wire logic brk_req
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence s_take;
        hsel && htrans[1] && hready;
    endsequence
    sequence s_pop;
        s_take ##0 (!hwrite && haddr[4:0] == dtu_pkg::OFF_FIFO);
    endsequence
    chk_brk_pulse: assert property (brk_req |=> !brk_req)
        else $error("brk_req longer than one cycle");
    chk_brk_cause: assert property (brk_req |-> $past(cpu_valid || cpu_exec))
        else $error("brk_req without a bus cycle");
    chk_port_quiet: assert property ($past(background_debug_port_busy) |-> !brk_req)
        else $error("brk_req after a debug port access");
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    chk_write_fast: assert property (s_take ##0 hwrite |=> hreadyout)
        else $error("write stalled");
    chk_read_fast: assert property (
        s_take ##0 (!hwrite && haddr[4:0] != dtu_pkg::OFF_FIFO) |=> hreadyout)
        else $error("register read stalled");
    chk_align_bound: assert property (s_pop |=> ##[0:8] hreadyout)
        else $error("store read waits too long");
    chk_wait_cause: assert property (
        $fell(hreadyout) |-> $past(hsel && htrans[1] && !hwrite))
        else $error("wait state without a read");
endmodule // dtu_unit_assertions

bind dtu_unit dtu_unit_assertions u_dtu_unit_assertions (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .cpu_valid(cpu_valid), .cpu_exec(cpu_exec),
    .background_debug_port_busy(background_debug_port_busy), .brk_req(brk_req)
);

// File: bench/dtu_cpu_model.sv
// Processor bus model feeding the monitored bus
`timescale 1ns/1ps
module dtu_cpu_model (
    // Clock
    input wire logic hclk,
    // Processor bus
    output logic cpu_valid,
    output logic cpu_rw,
    output logic [15:0] cpu_addr,
    output logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    output logic cpu_exec,
    output logic [15:0] cpu_exec_addr,
    output logic cpu_cof,
    output logic background_debug_port_busy
);
    initial begin
        {cpu_valid, cpu_rw, cpu_exec, cpu_cof, background_debug_port_busy} = 5'h00;
        {cpu_addr, cpu_exec_addr, cpu_wdata, cpu_rdata} = 48'h0;
    end
    // One cycle; an executed opcode comes without a data cycle
    task automatic cycle(input logic [15:0] a, input logic rw, input logic [7:0] wd,
                         input logic [7:0] rd, input logic ex, input logic cof,
                         input logic busy);
        @(posedge hclk);
        cpu_valid <= !ex;
        cpu_rw <= rw;
        cpu_addr <= a;
        cpu_wdata <= wd;
        cpu_rdata <= rd;
        cpu_exec <= ex;
        cpu_exec_addr <= a;
        cpu_cof <= cof;
        background_debug_port_busy <= busy;
        @(posedge hclk);
        // Idle buses show the inverse of their last value
        cpu_valid <= 1'b0;
        cpu_exec <= 1'b0;
        cpu_cof <= 1'b0;
        background_debug_port_busy <= 1'b0;
        cpu_addr <= ~a;
        cpu_wdata <= ~wd;
        cpu_rdata <= ~rd;
        cpu_exec_addr <= ~a;
    endtask
endmodule // dtu_cpu_model

// File: bench/test_debug_bus_trigger_capture.sv
// Self-checking bench of the debug trigger unit
`timescale 1ns/1ps
module test_debug_bus_trigger_capture;
    localparam logic [31:0] ALL = 32'hffffffff;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, brk_req, irq, cv, crw, cex, ccof, cbusy;
    logic [15:0] caddr, cxaddr;
    logic [7:0] cwd, crd;
    int bad_count = 0;
    int n_compared = 0;

    always #10 hclk = ~hclk;

    dtu_unit u_dtu_unit (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_valid(cv),
        .cpu_rw(crw), .cpu_addr(caddr), .cpu_wdata(cwd), .cpu_rdata(crd), .cpu_exec(cex),
        .cpu_exec_addr(cxaddr), .cpu_cof(ccof), .background_debug_port_busy(cbusy),
        .brk_req(brk_req), .irq(irq)
    );
    dtu_cpu_model u_cpu (
        .hclk(hclk), .cpu_valid(cv), .cpu_rw(crw), .cpu_addr(caddr), .cpu_wdata(cwd),
        .cpu_rdata(crd), .cpu_exec(cex), .cpu_exec_addr(cxaddr), .cpu_cof(ccof),
        .background_debug_port_busy(cbusy)
    );

    task automatic give_verdict();
        if (bad_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (hreadyout !== 1'b1) begin
            bad_count++;
            give_verdict();
        end
    endtask
    task automatic ahb(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {27'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check("register", rd & m, exp);
    endtask
    task automatic hit(input logic [15:0] a, input logic rw, input logic [7:0] wd,
                       input logic [7:0] r8, input logic ex, input logic bz, input logic e);
        u_cpu.cycle(a, rw, wd, r8, ex, 1'b0, bz);
        #1;
        check("brk_req", {31'h0, brk_req}, {31'h0, e});
    endtask

    task automatic t_regs();
        for (int a = 0; a < 32; a += 4) begin
            // An empty store reports its read slot as aligned once it has idled
            if (a[4:0] == dtu_pkg::OFF_STAT) begin
                rdc(a[4:0], ALL, 32'h1 << dtu_pkg::SB_ALIGNED);
            end else begin
                rdc(a[4:0], ALL, 32'h0);
            end
        end
        wr(5'h1c, ALL);
        rdc(5'h1c, ALL, 32'h0);
        check("irq", {31'h0, irq}, 32'h0);
    endtask
    task automatic t_brk();
        wr(dtu_pkg::OFF_CMPA, 32'h1234);
        wr(dtu_pkg::OFF_IMASK, 32'h4);
        wr(dtu_pkg::OFF_CTRL, 32'h1);
        hit(16'h1234, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
        @(posedge hclk);
        #1;
        check("irq", {31'h0, irq}, 32'h1);
        hit(16'h1235, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
        hit(16'h1234, 1'b1, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0);
        rdc(dtu_pkg::OFF_ISTAT, ALL, 32'h5);
        wr(dtu_pkg::OFF_ISTAT, 32'h7);
        rdc(dtu_pkg::OFF_ISTAT, ALL, 32'h0);
        check("irq", {31'h0, irq}, 32'h0);
        wr(dtu_pkg::OFF_IMASK, 32'h0);
        hit(16'h1234, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
        rdc(dtu_pkg::OFF_ISTAT, ALL, 32'h5);
        check("irq", {31'h0, irq}, 32'h0);
        wr(dtu_pkg::OFF_ISTAT, 32'h7);
    endtask
    task automatic t_dir();
        wr(dtu_pkg::OFF_CTRL, 32'h11);
        hit(16'h1234, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
        hit(16'h1234, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
        wr(dtu_pkg::OFF_CTRL, 32'h101);
        hit(16'h1234, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
        hit(16'h1234, 1'b1, 8'h00, 8'h00, 1'b1, 1'b0, 1'b1);
        // Either comparator, B qualified to write cycles only
        wr(dtu_pkg::OFF_CMPB, 32'h4321);
        wr(dtu_pkg::OFF_CTRL, 32'h43);
        hit(16'h4321, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
        hit(16'h4321, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
        hit(16'h1234, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
    endtask
    task automatic t_data();
        wr(dtu_pkg::OFF_CMPB, 32'h55);
        wr(dtu_pkg::OFF_CTRL, 32'h15);
        hit(16'h1234, 1'b0, 8'h55, 8'haa, 1'b0, 1'b0, 1'b1);
        hit(16'h1234, 1'b0, 8'haa, 8'h55, 1'b0, 1'b0, 1'b0);
        wr(dtu_pkg::OFF_CTRL, 32'h05);
        hit(16'h1234, 1'b0, 8'h55, 8'haa, 1'b0, 1'b0, 1'b0);
        hit(16'h1234, 1'b1, 8'haa, 8'h55, 1'b0, 1'b0, 1'b1);
    endtask
    task automatic t_cap();
        wr(dtu_pkg::OFF_CTRL, 32'h3a);
        hit(16'h1234, 1'b1, 8'h40, 8'h40, 1'b0, 1'b0, 1'b0);
        rdc(dtu_pkg::OFF_STAT, 32'h1f, 32'h0);
        wr(dtu_pkg::OFF_IMASK, 32'h2);
        wr(dtu_pkg::OFF_CTRL, 32'h3b);
        for (int i = 0; i < 9; i++) begin
            u_cpu.cycle(16'h1234, 1'b1, 8'h40 + i[7:0], 8'h40 + i[7:0], 1'b0, 1'b0, 1'b0);
            if (i == 0) rdc(dtu_pkg::OFF_STAT, 32'h1f, 32'h11);
        end
        rdc(dtu_pkg::OFF_STAT, 32'h1f, 32'h8);
        check("irq", {31'h0, irq}, 32'h1);
        for (int i = 0; i < 8; i++) rdc(dtu_pkg::OFF_FIFO, ALL, 32'h40 + i);
        rdc(dtu_pkg::OFF_STAT, 32'hf, 32'h0);
        wr(dtu_pkg::OFF_ISTAT, 32'h7);
        wr(dtu_pkg::OFF_CTRL, 32'h3b);
        for (int i = 0; i < 3; i++)
            u_cpu.cycle(16'h1234, 1'b1, 8'h60 + i[7:0], 8'h60 + i[7:0], 1'b0, 1'b0, 1'b0);
        wr(dtu_pkg::OFF_CTRL, 32'h3a);
        for (int i = 0; i < 3; i++) rdc(dtu_pkg::OFF_FIFO, ALL, 32'h60 + i);
        rdc(dtu_pkg::OFF_STAT, 32'hf, 32'h0);
    endtask
    task automatic t_trace();
        wr(dtu_pkg::OFF_CTRL, 32'h0d);
        u_cpu.cycle(16'h1234, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
        u_cpu.cycle(16'h3000, 1'b1, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0);
        wr(dtu_pkg::OFF_CTRL, 32'h0c);
        rdc(dtu_pkg::OFF_FIFO, ALL, 32'h3000);
        wr(dtu_pkg::OFF_CTRL, 32'h0f);
        u_cpu.cycle(16'h3100, 1'b1, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0);
        u_cpu.cycle(16'h1234, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
        u_cpu.cycle(16'h3200, 1'b1, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0);
        wr(dtu_pkg::OFF_CTRL, 32'h0e);
        rdc(dtu_pkg::OFF_STAT, 32'hf, 32'h1);
        rdc(dtu_pkg::OFF_FIFO, ALL, 32'h3100);
    endtask
    task automatic t_range();
        wr(dtu_pkg::OFF_CMPA, 32'h1000);
        wr(dtu_pkg::OFF_CMPB, 32'h2000);
        for (int m = 3; m < 5; m++) begin
            wr(dtu_pkg::OFF_CTRL, (m << 1) | 1);
            hit(16'h1800, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0, m == 3);
            hit(16'h2800, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0, m == 4);
        end
    endtask

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_brk();
        t_dir();
        t_data();
        t_cap();
        t_trace();
        t_range();
        give_verdict();
    end
endmodule // test_debug_bus_trigger_capture
